// ==== dv/adcsel_host.sv ====
/*
  Firmware side model: an AHB-Lite master doing single word transfers.
  Assumes hready is the slave's hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsel_host
(
  // Bus
  input wire logic         hclk,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  output var logic         hsel,
  output var logic [31:0]  haddr,
  output var logic [1:0]   htrans,
  output var logic         hwrite,
  output var logic [31:0]  hwdata
);
  initial
  begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0;
    if (w) hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// ==== dv/adcsel_properties.sv ====
/*
  Port checker for adcsel_ctrl, attached by bind.
  Assumes one clock, hclk, and a prescale left at its reset value.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsel_properties
  import adcsel_pkg::*;
(
  // Clock and reset
  input wire logic                      hclk,
  input wire logic                      hresetn,
  // Observed outputs
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire adcsel_pkg::adcsel_sel_type active_sel,
  input wire logic                      sensor_enable,
  input wire logic                      sample_hold,
  input wire logic                      done_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence held_s;
    sample_hold ##1 sample_hold;
  endsequence
  sequence sensor_sel_s;
    (active_sel.mux == ADCSEL_MUX_SENSOR) [*2];
  endsequence
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  sensor_on_a: assert property (sensor_sel_s |-> sensor_enable) else $error("sensor off");
  sensor_off_a: assert property ((active_sel.mux != ADCSEL_MUX_SENSOR) [*2] |-> !sensor_enable)
    else $error("sensor on");
  sel_locked_a: assert property (held_s |-> $stable(active_sel)) else $error("selection moved");
  // Prescale 2 gives a tick every fourth cycle
  sel_tick_a: assert property ($changed(active_sel) |=> $stable(active_sel) [*3])
    else $error("selection off tick");
  done_late_a: assert property ($rose(done_irq) |-> !sample_hold) else $error("done in hold");
  hold_ends_a: assert property ($rose(sample_hold) |-> ##[1:120] !sample_hold)
    else $error("hold too long");
endmodule
bind adcsel_ctrl adcsel_properties i_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .active_sel(active_sel),
  .sensor_enable(sensor_enable), .sample_hold(sample_hold), .done_irq(done_irq));
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
  Self-checking bench for adcsel_ctrl with a firmware master model.
  Assumes prescale stays at 2, so one converter tick is four hclk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import adcsel_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, over_q = 1'b0;
  logic [9:0] sample_q = 10'h0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic hsel, hwrite, hreadyout, hresp, sensor_enable, sample_hold, done_irq;
  adcsel_sleep_type sleep_q = 3'h0;
  adcsel_sel_type active_sel;
  logic [7:0] exp_sel, old_sel;
  logic [1:0] refs [4] = '{ADCSEL_REF_AVCC, ADCSEL_REF_INT, ADCSEL_REF_EXT, ADCSEL_REF_INT};
  int n_fail = 0, checks_done = 0, cyc = 0, t = 0;
  // 125 us of settling at 40 ns per cycle
  localparam int SETTLE_CYC = 3125;
  always #20 hclk = ~hclk;
  adcsel_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  adcsel_ctrl i_adcsel_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_i(sleep_q), .sample_i(sample_q), .over_ref_i(over_q),
    .active_sel(active_sel), .sensor_enable(sensor_enable), .sample_hold(sample_hold), .done_irq(done_irq));
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      final_report();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Tick phase is unknown, so allow one tick early and two late
  task chk_time(input int ticks);
    chk({31'h0, (cyc - t) >= ticks * 4 - 4 && (cyc - t) <= ticks * 4 + 8}, 32'h1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask
  task wait_irq;
    int k;
    k = 0;
    // Skip the edges where a just-cleared request still shows
    repeat (2) @(posedge hclk);
    while (done_irq !== 1'b1 && k < 400)
    begin
      @(posedge hclk);
      k++;
    end
    chk({31'h0, done_irq}, 32'h1);
  endtask
  initial
  begin
    void'($urandom(53695));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADCSEL_OFS_SELECT, 32'hff, {24'h0, ADCSEL_SELECT_RST});
    rd_chk(ADCSEL_OFS_CONTROL, 32'h700, {21'h0, ADCSEL_PS_RST, 8'h0});
    rd_chk(8'h10, 32'hffffffff, 32'h0);
    wr(ADCSEL_OFS_CONTROL, 32'h211);
    exp_sel = 8'($urandom_range(0, 255));
    wr(ADCSEL_OFS_SELECT, {24'h0, exp_sel});
    repeat (8) @(posedge hclk);
    rd_chk(ADCSEL_OFS_STATUS, 32'h1ff, {23'h0, exp_sel[5:0] == ADCSEL_MUX_SENSOR, exp_sel});
    sample_q <= 10'($urandom);
    wr(ADCSEL_OFS_CONTROL, 32'h213);
    t = cyc;
    repeat (8) @(posedge hclk);
    old_sel = exp_sel;
    exp_sel = ~exp_sel;
    wr(ADCSEL_OFS_SELECT, {24'h0, exp_sel});
    rd_chk(ADCSEL_OFS_STATUS, 32'hff, {24'h0, old_sel});
    wait_irq();
    chk_time(ADCSEL_CONV_FIRST);
    rd_chk(ADCSEL_OFS_STATUS, 32'hff, {24'h0, exp_sel});
    for (int i = 0; i < 4; i++)
    begin
      exp_sel = {refs[i], (i == 3) ? ADCSEL_MUX_SENSOR : 6'($urandom_range(0, 31))};
      over_q <= i[0];
      sample_q <= 10'($urandom);
      wr(ADCSEL_OFS_CONTROL, 32'h219);
      wr(ADCSEL_OFS_SELECT, {24'h0, exp_sel});
      repeat (SETTLE_CYC) @(posedge hclk);
      // Throwaway conversion after each reference or sensor change
      wr(ADCSEL_OFS_CONTROL, 32'h213);
      wait_irq();
      wr(ADCSEL_OFS_CONTROL, 32'h219);
      wr(ADCSEL_OFS_CONTROL, 32'h213);
      t = cyc;
      wait_irq();
      chk_time(ADCSEL_CONV_NORMAL);
      rd_chk(ADCSEL_OFS_RESULT, 32'h3ff, {22'h0, over_q ? ADCSEL_FULL_SCALE : sample_q});
      rd_chk(ADCSEL_OFS_STATUS, 32'h1ff, {23'h0, i == 3, exp_sel});
    end
    // Free running: change after the first done lands one conversion later
    wr(ADCSEL_OFS_CONTROL, 32'h219);
    old_sel = exp_sel;
    wr(ADCSEL_OFS_CONTROL, 32'h217);
    wait_irq();
    exp_sel = 8'h05;
    wr(ADCSEL_OFS_SELECT, {24'h0, exp_sel});
    wr(ADCSEL_OFS_CONTROL, 32'h21d);
    rd_chk(ADCSEL_OFS_STATUS, 32'hff, {24'h0, old_sel});
    wait_irq();
    rd_chk(ADCSEL_OFS_STATUS, 32'hff, {24'h0, exp_sel});
    wr(ADCSEL_OFS_CONTROL, 32'h219);
    wait_irq();
    wr(ADCSEL_OFS_CONTROL, 32'h219);
    repeat (80) @(posedge hclk);
    // Enabled, idle, single mode, interrupt on, then halt
    sleep_q <= 3'b111;
    t = cyc;
    wait_irq();
    chk_time(ADCSEL_CONV_NORMAL + 1);
    sleep_q <= 3'b000;
    wr(ADCSEL_OFS_CONTROL, 32'h219);
    repeat (2) @(posedge hclk);
    chk({31'h0, done_irq}, 32'h0);
    sleep_q <= 3'b101;
    repeat (80) @(posedge hclk);
    chk({31'h0, done_irq}, 32'h0);
    rd_chk(ADCSEL_OFS_CONTROL, 32'h1, 32'h1);
    // Wake from the other mode, then cycle the enable to force a long conversion
    sleep_q <= 3'b000;
    wr(ADCSEL_OFS_CONTROL, 32'h210);
    wr(ADCSEL_OFS_CONTROL, 32'h211);
    wr(ADCSEL_OFS_CONTROL, 32'h213);
    t = cyc;
    wait_irq();
    chk_time(ADCSEL_CONV_FIRST);
    final_report();
  end
endmodule
`default_nettype wire

// ==== include/adcsel_pkg.sv ====
/*
  Package for the converter selection and sleep-conversion control block:
  register offsets, field positions, reset values, timing counts and the
  carrier structs.
  Assumes a single AHB-Lite master and one clock, hclk.

  // Operation
  // - Selection is buffered in a temporary copy, copied to active until conversion starts.
  // - While converting, active selection is frozen against CPU writes.
  // - Copying resumes in the last converter clock cycle before done flag sets.
  // - Start bit write begins conversion at the next converter clock rising edge.
  // - Free running: channel change after first conversion applies one conversion later.
  // - Single ended inputs above reference give full-scale code.
  // - Three reference choices: analog supply, internal fixed, external pin.
  // - Sensor and driver enabled when sensor input selected; software uses internal ref.
  // - In noise-reduction or idle sleep, conversion starts once CPU halts.
  // - Completion interrupt wakes CPU; request still raised if woken earlier.
  // - Other sleep modes do not disable the converter automatically.
  // - Normal conversion lasts thirteen converter clock cycles.
*/
package adcsel_pkg;

  // Register byte addresses
  localparam logic [7:0] ADCSEL_OFS_SELECT  = 8'h00;
  localparam logic [7:0] ADCSEL_OFS_CONTROL = 8'h04;
  localparam logic [7:0] ADCSEL_OFS_STATUS  = 8'h08;
  localparam logic [7:0] ADCSEL_OFS_RESULT  = 8'h0c;

  // Select register fields
  localparam int ADCSEL_MUX_LSB  = 0;
  localparam int ADCSEL_MUX_W    = 6;
  localparam int ADCSEL_REFS_LSB = 6;
  localparam int ADCSEL_REFS_W   = 2;

  // Control register fields
  localparam int ADCSEL_CTL_EN    = 0;
  localparam int ADCSEL_CTL_START = 1;
  localparam int ADCSEL_CTL_AUTO  = 2;
  localparam int ADCSEL_CTL_DONE  = 3;
  localparam int ADCSEL_CTL_IE    = 4;
  localparam int ADCSEL_CTL_PS    = 8;
  localparam int ADCSEL_PS_W      = 3;

  // Status register fields
  localparam int ADCSEL_ST_ACT_MUX  = 0;
  localparam int ADCSEL_ST_ACT_REFS = 6;
  localparam int ADCSEL_ST_SENSOR   = 8;
  localparam int ADCSEL_ST_LOCKED   = 9;

  // Reset values
  localparam logic [7:0] ADCSEL_SELECT_RST = 8'h00;
  localparam logic [2:0] ADCSEL_PS_RST     = 3'h2;

  // Selection codes and the full-scale result code
  localparam logic [5:0] ADCSEL_MUX_SENSOR = 6'h27;
  localparam logic [1:0] ADCSEL_REF_AVCC   = 2'h1;
  localparam logic [1:0] ADCSEL_REF_INT    = 2'h3;
  localparam logic [1:0] ADCSEL_REF_EXT    = 2'h0;
  localparam logic [9:0] ADCSEL_FULL_SCALE = 10'h3ff;

  // Conversion timing in converter clock cycles
  localparam logic [4:0] ADCSEL_CONV_NORMAL = 5'd13;
  localparam logic [4:0] ADCSEL_CONV_FIRST  = 5'd25;
  localparam logic [4:0] ADCSEL_HOLD_FIRST  = 5'd14;
  localparam logic [4:0] ADCSEL_HOLD_NORMAL = 5'd2;

  typedef struct packed {
    logic [1:0] refs;
    logic [5:0] mux;
  } adcsel_sel_type;

  typedef struct packed {
    logic sleep_req;
    logic sleep_nr_idle;
    logic cpu_halted;
  } adcsel_sleep_type;

endpackage

// ==== logic/adcsel_ctrl.sv ====
/*
  Converter selection, start and completion control with noise-canceler
  sleep conversion, behind an AHB-Lite register slave.
  Assumes sleep status arrives from core logic on hclk; the analog sample
  value arrives on hclk and is taken at the last conversion cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module adcsel_ctrl
  import adcsel_pkg::*;
#(
  parameter int PS_MAX_LOG = 7
)
(
  // Clock and reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Sleep state from the core
  input  wire adcsel_pkg::adcsel_sleep_type sleep_i,
  // Analog side
  input  wire logic [9:0]               sample_i,
  input  wire logic                     over_ref_i,
  output var adcsel_pkg::adcsel_sel_type active_sel,
  output logic                          sensor_enable,
  output logic                          sample_hold,
  // Interrupt request to the core
  output logic                          done_irq
);

  import adcsel_pkg::*;

  initial
  begin
    if (PS_MAX_LOG < 1 || PS_MAX_LOG > 7)
      $error("PS_MAX_LOG out of range");
  end

  // Bus address phase capture
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        rd_pend_q;
  logic        bus_take;

  assign bus_take  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end
    else
    begin
      wr_pend_q <= bus_take && hwrite;
      rd_pend_q <= bus_take && !hwrite;
      if (bus_take)
        addr_q <= haddr[7:0];
    end
  end

  function automatic logic wr_to(input logic [7:0] ofs);
    wr_to = wr_pend_q && (addr_q == ofs);
  endfunction

  // Last prescaler count of one converter clock period
  function automatic logic [6:0] pre_top(input logic [2:0] ps);
    pre_top = (7'h01 << ps) - 7'h01;
  endfunction

  // Sample window length, longer while the analog side initialises
  function automatic logic [4:0] hold_len(input logic first);
    if (first)
      hold_len = ADCSEL_HOLD_FIRST;
    else
      hold_len = ADCSEL_HOLD_NORMAL;
  endfunction

  // Software-visible state, then internal counters, flags and strobes
  adcsel_sel_type temp_sel_q;
  logic           en_q;
  logic           auto_q;
  logic           ie_q;
  logic [2:0]     ps_q;
  logic           done_q;
  logic           start_q;
  logic [9:0]     result_q;
  logic           first_q;
  logic           busy_q;
  logic           start_req_q;
  logic           halted_q;
  logic [4:0]     cyc_q;
  logic [6:0]     pre_q;
  logic           tick;
  logic           last_cyc;
  logic           conv_end;
  logic           sleep_start;
  logic [4:0]     conv_len;
  logic [2:0]     ps_eff;
  logic           start_wr;
  logic           done_clr;

  // Control strobes; a process so the bus state read inside wr_to is seen
  always_comb
  begin
    start_wr = wr_to(ADCSEL_OFS_CONTROL) && hwdata[ADCSEL_CTL_START];
    done_clr = wr_to(ADCSEL_OFS_CONTROL) && hwdata[ADCSEL_CTL_DONE];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      temp_sel_q <= ADCSEL_SELECT_RST;
    else if (wr_to(ADCSEL_OFS_SELECT))
      temp_sel_q <= hwdata[ADCSEL_REFS_LSB+ADCSEL_REFS_W-1:ADCSEL_MUX_LSB];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q   <= 1'b0;
      auto_q <= 1'b0;
      ie_q   <= 1'b0;
      ps_q   <= ADCSEL_PS_RST;
    end
    else if (wr_to(ADCSEL_OFS_CONTROL))
    begin
      en_q   <= hwdata[ADCSEL_CTL_EN];
      auto_q <= hwdata[ADCSEL_CTL_AUTO];
      ie_q   <= hwdata[ADCSEL_CTL_IE];
      ps_q   <= hwdata[ADCSEL_CTL_PS+ADCSEL_PS_W-1:ADCSEL_CTL_PS];
    end
  end

  // Prescaler held in reset while disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_q <= 7'h00;
    else if (!en_q)
      pre_q <= 7'h00;
    else if (tick)
      pre_q <= 7'h00;
    else
      pre_q <= pre_q + 7'h01;
  end

  // Settings above the build limit run at the limit
  always_comb
  begin
    if (ps_q > 3'(PS_MAX_LOG))
      ps_eff = 3'(PS_MAX_LOG);
    else
      ps_eff = ps_q;
  end

  // One tick per converter clock rising edge; count restarts there so the period follows ps
  assign tick = en_q && (pre_q == pre_top(ps_eff));

  // Start request waits for the next converter edge
  assign sleep_start = sleep_i.sleep_req && sleep_i.sleep_nr_idle && sleep_i.cpu_halted
                       && !halted_q && en_q && !busy_q && !start_req_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      halted_q <= 1'b0;
    else
      halted_q <= sleep_i.sleep_req && sleep_i.cpu_halted;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      start_req_q <= 1'b0;
    else if (!en_q)
      start_req_q <= 1'b0;
    else if (start_wr && !busy_q)
      start_req_q <= 1'b1;
    else if (sleep_start)
      start_req_q <= 1'b1;
    else if (tick)
      start_req_q <= 1'b0;
  end

  assign conv_len = first_q ? ADCSEL_CONV_FIRST : ADCSEL_CONV_NORMAL;
  assign last_cyc = busy_q && (cyc_q == conv_len - 5'd1);
  assign conv_end = last_cyc && tick;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_q <= 1'b0;
      cyc_q  <= 5'd0;
    end
    else if (!en_q)
    begin
      busy_q <= 1'b0;
      cyc_q  <= 5'd0;
    end
    else if (tick)
    begin
      if (conv_end)
      begin
        busy_q <= auto_q;
        cyc_q  <= 5'd0;
      end
      else if (busy_q)
        cyc_q <= cyc_q + 5'd1;
      else if (start_req_q)
      begin
        busy_q <= 1'b1;
        cyc_q  <= 5'd0;
      end
    end
  end

  // First conversion after enable takes the long path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      first_q <= 1'b1;
    else if (!en_q)
      first_q <= 1'b1;
    else if (conv_end)
      first_q <= 1'b0;
  end

  // Active selection copied only on converter edges, frozen while converting except in the last cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      active_sel <= ADCSEL_SELECT_RST;
    else if (tick && (!busy_q || last_cyc))
      active_sel <= temp_sel_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sensor_enable <= 1'b0;
    else
      sensor_enable <= (active_sel.mux == ADCSEL_MUX_SENSOR);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sample_hold <= 1'b0;
    else
      sample_hold <= busy_q && (cyc_q < hold_len(first_q));
  end

  // Result capture, clipped at full scale above reference
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      result_q <= 10'h000;
    else if (conv_end)
      result_q <= over_ref_i ? ADCSEL_FULL_SCALE : sample_i;
  end

  // Done flag: set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      done_q <= 1'b0;
    else if (conv_end)
      done_q <= 1'b1;
    else if (done_clr)
      done_q <= 1'b0;
  end

  // Request stays up whether or not the CPU already woke
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      done_irq <= 1'b0;
    else
      done_irq <= (done_q || conv_end) && ie_q;
  end

  assign start_q = busy_q || start_req_q;

  // Read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (bus_take && !hwrite)
    begin
      unique case (haddr[7:0])
        ADCSEL_OFS_SELECT:  hrdata <= {24'h000000, temp_sel_q};
        ADCSEL_OFS_CONTROL: hrdata <= {21'h000000, ps_q, 3'h0, ie_q, done_q, auto_q, start_q, en_q};
        ADCSEL_OFS_STATUS:  hrdata <= {22'h000000, busy_q, sensor_enable, active_sel};
        ADCSEL_OFS_RESULT:  hrdata <= {22'h000000, result_q};
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire
